/* File: common/afs_pkg.sv */
// afs_pkg: constants, register map and carrier types of the amplifier fault supervisor
// assumes a 10 MHz hclk and an ahb-lite master with single word transfers
package afs_pkg;

    // =========================================================
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int RESTART_MS = 200;
    localparam int RESTART_FS_HZ = 48_000;
    localparam int RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
    localparam int RESTART_W = 22;

    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_EVENT = 8'h04;
    localparam logic [7:0] OFS_EV_CLR = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;

    // =========================================================
    // fault bit positions, shared by status, event, clear and enable
    localparam int NFLT = 5;
    localparam int B_OTP = 0;
    localparam int B_UVP = 1;
    localparam int B_OVP = 2;
    localparam int B_OCP = 3;
    localparam int B_SCP = 4;

    // control bits
    localparam int C_BATSG = 0;
    localparam int C_BOOST = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;

    // =========================================================
    // amplifier state
    typedef enum logic [1:0] {
        AMP_RUN = 2'b00,
        AMP_FLOAT = 2'b01,
        AMP_OFF = 2'b10,
        AMP_WAIT = 2'b11
    } afs_amp_t;

    // comparator inputs as one bundle
    typedef struct packed {
        logic scp;
        logic ocp;
        logic ovp;
        logic uvp;
        logic otp;
    } afs_flt_t;

    // controls toward the power stages
    typedef struct packed {
        logic stage_float;
        logic stage_off;
        logic cur_limit;
        logic boost_follow;
        logic gain_reduce;
    } afs_pwr_t;

endpackage

/* File: hw/afs_sync.sv */
// afs_sync: two flip-flop synchroniser for a bundle of asynchronous levels
// assumes levels held much longer than one hclk period
`timescale 1ns/1ps
`default_nettype none
module afs_sync #(
    parameter int W = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // =========================================================
    // synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: hw/afs_timer.sv */
// afs_timer: restart timer, loads on start and pulses done when it expires
// assumes start and done are on the hclk domain
`timescale 1ns/1ps
`default_nettype none
module afs_timer #(
    parameter int W = 22
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_r;

    // =========================================================
    // down counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_r <= load;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (cnt_r <= W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    cnt_r <= cnt_r - W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/afs_top.sv */
// afs_top: amplifier fault supervisor with ahb-lite register slave
// assumes comparator levels arrive asynchronously; bus on hclk
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module afs_top
    import afs_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire afs_pkg::afs_flt_t flt_in,
    input wire logic bat_low,
    input wire logic need_above_bat,
    output afs_pkg::afs_pwr_t pwr,
    output logic irq
);
    import afs_pkg::*;

    afs_flt_t flt_s;
    logic [1:0] lvl_s;
    logic [NFLT-1:0] live;
    logic [NFLT-1:0] event_r;
    logic [NFLT-1:0] event_nxt;
    logic [NFLT-1:0] live_d_r;
    logic [NFLT-1:0] irq_en_r;
    logic [1:0] ctrl_r;
    afs_amp_t state_r;
    afs_amp_t state_nxt;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic ph_we_r;
    logic [7:0] ph_addr_r;
    logic [NFLT-1:0] clr_pulse;

    // =========================================================
    // input synchronisers
    afs_sync #(.W(NFLT)) u_sync_flt (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(flt_in),
        .q(flt_s)
    );

    afs_sync #(.W(2)) u_sync_lvl (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({need_above_bat, bat_low}),
        .q(lvl_s)
    );

    assign live = flt_s;

    // =========================================================
    // restart timer
    afs_timer #(.W(RESTART_W)) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(tmr_start),
        .load(RESTART_W'(RESTART_CYCLES)),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // =========================================================
    // amplifier state machine
    always_comb
    begin
        state_nxt = state_r;
        tmr_start = 1'b0;
        case (state_r)
            AMP_RUN:
            begin
                if (flt_s.scp)
                begin
                    state_nxt = AMP_OFF;
                    tmr_start = 1'b1;
                end
                else if (flt_s.otp || flt_s.uvp)
                begin
                    state_nxt = AMP_FLOAT;
                    tmr_start = flt_s.otp;
                end
                else if (flt_s.ovp)
                begin
                    state_nxt = AMP_WAIT;
                end
            end
            AMP_FLOAT:
            begin
                if (flt_s.scp)
                begin
                    state_nxt = AMP_OFF;
                    tmr_start = 1'b1;
                end
                else if (flt_s.uvp)
                begin
                    state_nxt = AMP_FLOAT;
                    tmr_start = 1'b1;
                end
                else if (tmr_done)
                begin
                    state_nxt = AMP_RUN;
                end
                else if (!tmr_busy)
                begin
                    tmr_start = 1'b1;
                end
            end
            AMP_OFF:
            begin
                if (tmr_done)
                begin
                    state_nxt = AMP_RUN;
                end
            end
            AMP_WAIT:
            begin
                // a short or a floating fault must not wait out the rail timer
                if (flt_s.scp)
                begin
                    state_nxt = AMP_OFF;
                    tmr_start = 1'b1;
                end
                else if (flt_s.otp || flt_s.uvp)
                begin
                    state_nxt = AMP_FLOAT;
                    tmr_start = 1'b1;
                end
                else if (flt_s.ovp)
                begin
                    tmr_start = 1'b1;
                end
                else if (tmr_done)
                begin
                    state_nxt = AMP_RUN;
                end
                else if (!tmr_busy)
                begin
                    tmr_start = 1'b1;
                end
            end
            default:
            begin
                state_nxt = AMP_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= AMP_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // =========================================================
    // power stage controls
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwr <= '0;
        end
        else
        begin
            pwr.stage_float <= (state_nxt == AMP_FLOAT);
            pwr.stage_off <= (state_nxt == AMP_OFF);
            pwr.cur_limit <= flt_s.ocp && !flt_s.scp;
            pwr.boost_follow <= flt_s.ovp || !ctrl_r[C_BOOST]
                || !lvl_s[1];
            pwr.gain_reduce <= ctrl_r[C_BATSG] && lvl_s[0];
        end
    end

    // =========================================================
    // sticky events and interrupt
    always_comb
    begin
        event_nxt = (event_r & ~clr_pulse) | (live & ~live_d_r);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            event_r <= '0;
            live_d_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            live_d_r <= live;
            event_r <= event_nxt;
            irq <= |((event_nxt | live) & irq_en_r);
        end
    end

    // =========================================================
    // ahb-lite slave
    assign clr_pulse = (ph_we_r && ph_addr_r == OFS_EV_CLR) ? hwdata[NFLT-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_we_r <= 1'b0;
            ph_addr_r <= '0;
        end
        else if (hready)
        begin
            ph_we_r <= hsel && htrans[1] && hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_en_r <= '0;
            ctrl_r <= CTRL_RST;
        end
        else if (ph_we_r)
        begin
            if (ph_addr_r == OFS_IRQ_EN)
            begin
                irq_en_r <= hwdata[NFLT-1:0];
            end
            else if (ph_addr_r == OFS_CTRL)
            begin
                ctrl_r <= hwdata[1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= '0;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            if (haddr[7:0] == OFS_STATUS)
            begin
                hrdata <= {{(32-NFLT){1'b0}}, live};
            end
            else if (haddr[7:0] == OFS_EVENT)
            begin
                hrdata <= {{(32-NFLT){1'b0}}, event_nxt};
            end
            else if (haddr[7:0] == OFS_IRQ_EN)
            begin
                hrdata <= {{(32-NFLT){1'b0}}, irq_en_r};
            end
            else if (haddr[7:0] == OFS_CTRL)
            begin
                hrdata <= {30'h0, ctrl_r};
            end
            else if (haddr[7:0] == OFS_STATE)
            begin
                hrdata <= {30'h0, state_nxt};
            end
            else
            begin
                hrdata <= '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/afs_analog_model.sv */
// afs_analog_model: comparator front end facing the supervisor
// assumes the bench sets wanted levels; outputs move off the clock edge
`timescale 1ns/1ps
`default_nettype none
module afs_analog_model
    import afs_pkg::*;
(
    input wire afs_pkg::afs_flt_t want_flt,
    input wire logic want_bat,
    input wire logic want_need,
    output afs_pkg::afs_flt_t flt_in,
    output logic bat_low,
    output logic need_above_bat
);
    // ==========
    // comparators settle unrelated to hclk
    assign #37 flt_in = want_flt;
    assign #41 bat_low = want_bat;
    assign #43 need_above_bat = want_need;
endmodule
`default_nettype wire

/* File: tb/afs_top_asserts.sv */
// afs_top_asserts: port timing checks of the fault supervisor
// assumes a bind to afs_top with a short restart count
`timescale 1ns/1ps
`default_nettype none
module afs_top_asserts
    import afs_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire afs_pkg::afs_flt_t flt_in,
    input wire logic bat_low,
    input wire logic need_above_bat,
    input wire afs_pkg::afs_pwr_t pwr
);
    // ==========
    // cycles with no fault input
    logic [7:0] quiet_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            quiet_r <= 8'h00;
        else if (flt_in != 5'h00)
            quiet_r <= 8'h00;
        else if (quiet_r != 8'hff)
            quiet_r <= quiet_r + 8'h01;
    end
    // ==========
    // assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_otp_float: assert property ($rose(flt_in.otp) |-> ##[1:4] pwr.stage_float)
        else $error("no float after over-temperature");
    a_uvp_float: assert property (flt_in.uvp [*5] |-> pwr.stage_float)
        else $error("no float in undervoltage");
    a_ovp_follow: assert property (flt_in.ovp [*5] |-> pwr.boost_follow)
        else $error("no follower in overvoltage");
    a_scp_off: assert property ($rose(flt_in.scp) |-> ##[1:4] pwr.stage_off)
        else $error("no shutdown on short");
    a_ocp_limit: assert property ((flt_in.ocp && !flt_in.scp) [*5] |-> pwr.cur_limit)
        else $error("no current limit");
    a_need_follow: assert property (!need_above_bat [*5] |-> pwr.boost_follow)
        else $error("no follower at low demand");
    a_gain_off: assert property (!bat_low [*5] |-> !pwr.gain_reduce)
        else $error("gain reduced with good battery");
    a_restart_done: assert property
        (int'(quiet_r) >= RESTART_CYCLES + 8 |-> !pwr.stage_float && !pwr.stage_off)
        else $error("stages not restarted");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule
bind afs_top afs_top_asserts #(.RESTART_CYCLES(RESTART_CYCLES)) afs_top_asserts_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .flt_in(flt_in),
    .bat_low(bat_low),
    .need_above_bat(need_above_bat),
    .pwr(pwr)
);
`default_nettype wire

/* File: tb/amp_fault_supervisor_test.sv */
// amp_fault_supervisor_test: self-checking bench of the fault supervisor
// assumes afs_top, afs_analog_model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module amp_fault_supervisor_test;
    import afs_pkg::*;
    localparam int RC = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    afs_flt_t want_flt = '0;
    logic want_bat = 1'b0;
    logic want_need = 1'b1;
    afs_flt_t flt_in;
    logic bat_low;
    logic need_above_bat;
    afs_pwr_t pwr;
    logic irq;
    logic [31:0] q;
    int failures = 0;
    int total_checks = 0;
    always #50 hclk = ~hclk;
    afs_top #(.RESTART_CYCLES(RC)) afs_top_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .flt_in(flt_in),
        .bat_low(bat_low),
        .need_above_bat(need_above_bat),
        .pwr(pwr),
        .irq(irq)
    );
    afs_analog_model afs_analog_model_i (
        .want_flt(want_flt),
        .want_bat(want_bat),
        .want_need(want_need),
        .flt_in(flt_in),
        .bat_low(bat_low),
        .need_above_bat(need_above_bat)
    );
    // ==========
    // shared tasks
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_regs();
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, {30'h0, CTRL_RST});
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h20, 32'hffff);
        bus(1'b0, OFS_EV_CLR, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_STATUS, 32'h1f);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_faults();
        int pb [5] = '{4, 4, 1, 2, 3};
        for (int b = 0; b < NFLT; b++)
        begin
            want_flt <= afs_flt_t'(5'h1 << b);
            wt(6);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk(q, 32'h1 << b);
            chk(pwr[pb[b]], 1'b1);
            if (b == B_OVP || b == B_OCP)
                chk(pwr[4:3], 2'h0);
            want_flt <= '0;
            wt(RC + 10);
            chk(pwr[4:3], 2'h0);
            bus(1'b0, OFS_EVENT, 32'h0);
            chk(q, 32'h1 << b);
            bus(1'b1, OFS_EV_CLR, 32'h1 << b);
            bus(1'b0, OFS_EVENT, 32'h0);
            chk(q, 32'h0);
        end
    endtask
    task automatic t_uvp();
        want_flt <= 5'h02;
        wt(30);
        want_flt <= '0;
        wt(10);
        chk(pwr.stage_float, 1'b1);
        wt(RC + 5);
        chk(pwr.stage_float, 1'b0);
        bus(1'b1, OFS_EV_CLR, 32'h1f);
    endtask
    task automatic t_scp();
        int rises = 0;
        logic prev = 1'b1;
        want_flt <= 5'h10;
        wt(6);
        repeat (80)
        begin
            @(posedge hclk);
            if (pwr.stage_off && !prev)
                rises++;
            prev = pwr.stage_off;
        end
        chk(32'(rises >= 2), 32'h1);
        want_flt <= '0;
        wt(RC + 10);
        chk(pwr.stage_off, 1'b0);
        bus(1'b1, OFS_EV_CLR, 32'h1f);
    endtask
    task automatic t_ovp_short();
        want_flt <= 5'h04;
        wt(6);
        bus(1'b0, OFS_STATE, 32'h0);
        chk(q, {30'h0, AMP_WAIT});
        want_flt <= 5'h14;
        wt(6);
        chk(pwr.stage_off, 1'b1);
        bus(1'b0, OFS_STATE, 32'h0);
        chk(q, {30'h0, AMP_OFF});
        want_flt <= '0;
        wt(RC + 10);
        chk(pwr[4:3], 2'h0);
        bus(1'b1, OFS_EV_CLR, 32'h1f);
    endtask
    task automatic t_irq();
        bus(1'b1, OFS_IRQ_EN, 32'h1 << B_OCP);
        want_flt <= 5'h08;
        wt(6);
        chk(irq, 1'b1);
        want_flt <= '0;
        wt(6);
        chk(irq, 1'b1);
        bus(1'b1, OFS_EV_CLR, 32'h1 << B_OCP);
        wt(2);
        chk(irq, 1'b0);
        want_flt <= 5'h01;
        wt(6);
        chk(irq, 1'b0);
        want_flt <= '0;
        wt(RC + 10);
        bus(1'b1, OFS_EV_CLR, 32'h1f);
        bus(1'b1, OFS_IRQ_EN, 32'h0);
    endtask
    task automatic t_gain();
        bus(1'b1, OFS_CTRL, 32'h3);
        want_bat <= 1'b1;
        wt(6);
        chk(pwr.gain_reduce, 1'b1);
        bus(1'b1, OFS_CTRL, 32'h2);
        wt(4);
        chk(pwr.gain_reduce, 1'b0);
        want_need <= 1'b0;
        wt(6);
        chk(pwr.boost_follow, 1'b1);
        want_need <= 1'b1;
        wt(6);
        chk(pwr.boost_follow, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h0);
        wt(4);
        chk(pwr.boost_follow, 1'b1);
        bus(1'b1, OFS_CTRL, 32'h2);
        want_bat <= 1'b0;
    endtask
    // ==========
    // main sequence and watchdog
    initial
    begin
        wt(8);
        hresetn <= 1'b1;
        t_regs();
        t_faults();
        t_uvp();
        t_scp();
        t_ovp_short();
        t_irq();
        t_gain();
        print_verdict();
    end
    initial
    begin
        wt(5000);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
